// File: logic/tmrpre_map.vh
// Register offsets, field positions and constants for the counter block
`ifndef TMRPRE_MAP_VH
`define TMRPRE_MAP_VH
`define TMRPRE_OFS_COUNT 4'h1
`define TMRPRE_OFS_CONFIG 4'h2
`define TMRPRE_OFS_DIR 4'h3
`define TMRPRE_OFS_STATUS 4'h4
`define TMRPRE_CFG_RESET 8'hff
`define TMRPRE_DIR_RESET 8'h3f
`define TMRPRE_COUNT_RESET 8'h00
`define TMRPRE_BIT_WAKE 7
`define TMRPRE_BIT_PULLUP 6
`define TMRPRE_BIT_SRC 5
`define TMRPRE_BIT_EDGE 4
`define TMRPRE_BIT_ASSIGN 3
`define TMRPRE_PIN_A 0
`define TMRPRE_PIN_B 1
`define TMRPRE_PIN_SHARED 2
`define TMRPRE_PIN_D 3
`define TMRPRE_INSTR_DIV 2'h3
`endif

// File: logic/tmrpre_divider.v
// Shared divider: 8-bit ripple count with selectable tap
`timescale 1ns/1ns
module tmrpre_divider #(
  parameter WIDTH = 8
) (
  input wire ref_clk,
  input wire reset_n,
  input wire clear,
  input wire tick_in,
  input wire to_watchdog,
  input wire [2:0] ratio,
  output reg tick_out
);
  reg [WIDTH-1:0] div_reg;
  reg [WIDTH-1:0] div_next;
  reg [WIDTH:0] carry;
  reg hit;
  integer i;

  always @* begin
    carry = {(WIDTH+1){1'b0}};
    carry[0] = tick_in;
    for (i = 0; i < WIDTH; i = i + 1) begin
      carry[i+1] = carry[i] & div_reg[i];
    end
    div_next = div_reg + {{(WIDTH-1){1'b0}}, tick_in};
    if (clear) begin
      div_next = {WIDTH{1'b0}};
    end
    // Counter taps 1:2..1:256, watchdog 1:1..1:128
    if (to_watchdog) begin
      hit = (ratio == 3'h0) ? tick_in : carry[ratio];
    end else begin
      hit = carry[{1'b0, ratio} + 4'h1];
    end
  end

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_reg <= {WIDTH{1'b0}};
      tick_out <= 1'b0;
    end else begin
      div_reg <= div_next;
      tick_out <= hit & ~clear;
    end
  end
endmodule

// File: logic/tmrpre_core.v
// Counter, shared divider and pin configuration behind Avalon-MM
`timescale 1ns/1ns
`include "tmrpre_map.vh"
module tmrpre_core #(
  parameter PINS = 6
) (
  input wire ref_clk,
  input wire reset_n,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire ext_count_input,
  output reg watchdog_tick,
  output reg [PINS-1:0] pin_input_mode,
  output reg [PINS-1:0] pin_wake_enable,
  output reg [PINS-1:0] pin_pullup_enable
);
  localparam BUS_IDLE = 1'b0;
  localparam BUS_ANSWER = 1'b1;

  reg [7:0] count_value_reg;
  reg [7:0] count_value_next;
  reg [7:0] config_reg;
  reg [7:0] config_next;
  reg [7:0] dir_reg;
  reg [7:0] dir_next;
  reg [1:0] instr_div_reg;
  reg pin_prev_reg;
  reg bus_state_reg;
  reg bus_state_next;
  reg div_clear_reg;
  reg div_clear_next;
  reg [31:0] readdata_next;
  reg instr_tick;
  reg pin_edge;
  reg src_tick;
  reg div_in;
  reg bus_req;
  reg wr_accept;
  reg rd_take;
  reg wr_count;
  reg wr_config;
  reg wr_dir;
  wire div_tick;
  wire [PINS-1:0] wake_pins;
  wire [7:0] wake_byte;
  wire [7:0] pullup_byte;
  genvar g;

  // Status word lanes; lanes above the pin count read zero
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_lane
      if (g < PINS) begin : g_used
        assign wake_byte[g] = pin_wake_enable[g];
        assign pullup_byte[g] = pin_pullup_enable[g];
      end else begin : g_spare
        assign wake_byte[g] = 1'b0;
        assign pullup_byte[g] = 1'b0;
      end
    end
  endgenerate

  // Instruction cycle clock is the base clock divided by four
  always @* begin
    instr_tick = (instr_div_reg == `TMRPRE_INSTR_DIV);
    if (config_reg[`TMRPRE_BIT_EDGE]) begin
      pin_edge = pin_prev_reg & ~ext_count_input;
    end else begin
      pin_edge = ~pin_prev_reg & ext_count_input;
    end
    src_tick = config_reg[`TMRPRE_BIT_SRC] ? pin_edge : instr_tick;
    div_in = config_reg[`TMRPRE_BIT_ASSIGN] ? instr_tick : src_tick;
  end

  // One wait state: a request is answered on the edge after it is seen
  always @* begin
    bus_req = avs_read | avs_write;
    bus_state_next = BUS_IDLE;
    case (bus_state_reg)
      BUS_IDLE: begin
        if (bus_req) begin
          bus_state_next = BUS_ANSWER;
        end
      end
      BUS_ANSWER: begin
        bus_state_next = BUS_IDLE;
      end
      default: begin
        bus_state_next = BUS_IDLE;
      end
    endcase
  end

  // Writes land only on the edge at which waitrequest is seen low
  always @* begin
    wr_accept = avs_write & (bus_state_reg == BUS_ANSWER);
    rd_take = avs_read & (bus_state_reg == BUS_IDLE);
    wr_count = 1'b0;
    wr_config = 1'b0;
    wr_dir = 1'b0;
    if (wr_accept) begin
      case (avs_address)
        `TMRPRE_OFS_COUNT: begin
          wr_count = 1'b1;
        end
        `TMRPRE_OFS_CONFIG: begin
          wr_config = 1'b1;
        end
        `TMRPRE_OFS_DIR: begin
          wr_dir = 1'b1;
        end
        default: begin
          wr_count = 1'b0;
        end
      endcase
    end
  end

  // A new setting or count restarts the divider from zero
  always @* begin
    config_next = config_reg;
    dir_next = dir_reg;
    div_clear_next = 1'b0;
    if (wr_config) begin
      config_next = avs_writedata[7:0];
      div_clear_next = 1'b1;
    end
    if (wr_count) begin
      div_clear_next = 1'b1;
    end
    if (wr_dir) begin
      dir_next = {2'b00, avs_writedata[5:0]};
    end
  end

  // Only the counter and the status word read back
  always @* begin
    readdata_next = 32'h0000_0000;
    if (rd_take) begin
      case (avs_address)
        `TMRPRE_OFS_COUNT: begin
          readdata_next = {24'h00_0000, count_value_reg};
        end
        `TMRPRE_OFS_STATUS: begin
          readdata_next = {16'h0000, wake_byte, pullup_byte};
        end
        default: begin
          readdata_next = 32'h0000_0000;
        end
      endcase
    end
  end

  tmrpre_divider #(
    .WIDTH(8)
  ) u_div (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .clear(div_clear_reg),
    .tick_in(div_in),
    .to_watchdog(config_reg[`TMRPRE_BIT_ASSIGN]),
    .ratio(config_reg[2:0]),
    .tick_out(div_tick)
  );

  always @* begin
    count_value_next = count_value_reg;
    if (config_reg[`TMRPRE_BIT_ASSIGN]) begin
      if (src_tick) begin
        count_value_next = count_value_reg + 8'h01;
      end
    end else if (div_tick) begin
      count_value_next = count_value_reg + 8'h01;
    end
    if (wr_count) begin
      count_value_next = avs_writedata[7:0];
    end
  end

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      count_value_reg <= `TMRPRE_COUNT_RESET;
      config_reg <= `TMRPRE_CFG_RESET;
      dir_reg <= `TMRPRE_DIR_RESET;
      instr_div_reg <= 2'h0;
      pin_prev_reg <= 1'b0;
      bus_state_reg <= BUS_IDLE;
      div_clear_reg <= 1'b0;
      avs_readdata <= 32'h0000_0000;
      avs_waitrequest <= 1'b1;
      watchdog_tick <= 1'b0;
    end else begin
      instr_div_reg <= instr_div_reg + 2'h1;
      pin_prev_reg <= ext_count_input;
      count_value_reg <= count_value_next;
      config_reg <= config_next;
      dir_reg <= dir_next;
      bus_state_reg <= bus_state_next;
      div_clear_reg <= div_clear_next;
      avs_readdata <= readdata_next;
      avs_waitrequest <= (bus_state_next != BUS_ANSWER);
      watchdog_tick <= config_reg[`TMRPRE_BIT_ASSIGN] ? div_tick
        : instr_tick;
    end
  end

  generate
    for (g = 0; g < PINS; g = g + 1) begin : g_pin
      assign wake_pins[g] = (g == `TMRPRE_PIN_A) || (g == `TMRPRE_PIN_B) ||
        (g == `TMRPRE_PIN_D);
      always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
          pin_input_mode[g] <= 1'b1;
          pin_wake_enable[g] <= 1'b0;
          pin_pullup_enable[g] <= 1'b0;
        end else begin
          if (g == `TMRPRE_PIN_SHARED) begin
            pin_input_mode[g] <= dir_reg[g] |
              config_reg[`TMRPRE_BIT_SRC];
          end else begin
            pin_input_mode[g] <= dir_reg[g];
          end
          pin_wake_enable[g] <= wake_pins[g] & dir_reg[g] &
            ~config_reg[`TMRPRE_BIT_WAKE];
          pin_pullup_enable[g] <= wake_pins[g] & dir_reg[g] &
            ~config_reg[`TMRPRE_BIT_PULLUP];
        end
      end
    end
  endgenerate
endmodule

// File: test/tmrpre_sva.sv
// Assertions on the counter block ports
`timescale 1ns/1ns
module tmrpre_sva (
  input logic ref_clk,
  input logic reset_n,
  input logic [3:0] avs_address,
  input logic avs_read,
  input logic avs_write,
  input logic [31:0] avs_writedata,
  input logic [31:0] avs_readdata,
  input logic avs_waitrequest,
  input logic [5:0] pin_input_mode,
  input logic [5:0] pin_wake_enable,
  input logic [5:0] pin_pullup_enable
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  wire ack = !avs_waitrequest;
  wire cfg = avs_write && ack && avs_address == 4'h2;
  wire rd = avs_read && ack;
  a_wait_pulse: assert property (ack |=> !ack) else $error("ack");
  a_wake_dir: assert property (!(pin_wake_enable & ~pin_input_mode))
    else $error("wake");
  a_pull_dir: assert property (
    !(pin_pullup_enable & ~pin_input_mode)) else $error("pull");
  a_spare_pins: assert property (
    !((pin_wake_enable | pin_pullup_enable) & 6'h34)) else $error("spare");
  a_cfg_unread: assert property (
    rd && avs_address == 4'h2 |-> !avs_readdata) else $error("cfg");
  a_count_byte: assert property (
    rd && avs_address == 4'h1 |-> !avs_readdata[31:8]) else $error("byte");
  a_pin_forced: assert property (
    cfg && avs_writedata[5] |-> ##[1:3] pin_input_mode[2]) else $error("pin");
  a_wake_off: assert property (
    cfg && avs_writedata[7] |-> ##[1:3] !pin_wake_enable) else $error("off");
endmodule
bind tmrpre_core tmrpre_sva chk (.ref_clk, .reset_n, .avs_address,
  .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
  .pin_input_mode, .pin_wake_enable, .pin_pullup_enable);

// File: test/tmrpre_pulse.sv
// Pulse source on the external count pin
`timescale 1ns/1ns
module tmrpre_pulse (
  input logic ref_clk,
  input logic run,
  output logic pin
);
  logic [2:0] cnt_reg = 3'h0;
  initial pin = 1'b0;
  always @(posedge ref_clk) begin
    cnt_reg <= cnt_reg + 3'h1;
    if (run && cnt_reg == 3'h7) begin
      pin <= !pin;
    end
  end
endmodule

// File: test/tmrpre_tb.sv
// Self-checking bench for the counter block
`timescale 1ns/1ns
module testbench;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata, v, m, exp_q[$];
  logic avs_waitrequest, ext_count_input, watchdog_tick, run = 1'b0;
  logic hung = 1'b0;
  logic [5:0] pin_input_mode, pin_wake_enable, pin_pullup_enable, p;
  logic [7:0] d, e, ticks;
  int n_errors = 0, tests_run = 0, seed = 59794, i;
  always #4 ref_clk = !ref_clk;
  tmrpre_core uut (.ref_clk, .reset_n, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
    .ext_count_input, .watchdog_tick, .pin_input_mode,
    .pin_wake_enable, .pin_pullup_enable);
  tmrpre_pulse src (.ref_clk, .run, .pin(ext_count_input));
  task print_verdict;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task compare_read(input logic [31:0] got, input logic [31:0] want);
    tests_run++;
    if (got !== want) begin
      $display("CHECK FAILED %0t %h %h", $time, got, want);
      n_errors++;
    end
  endtask
  task compare_mode(input logic [5:0] got, input logic [5:0] want);
    tests_run++;
    if (got !== want) begin
      $display("CHECK FAILED %0t %h %h", $time, got, want);
      n_errors++;
    end
  endtask
  task compare_ticks(input logic [7:0] got, input logic [7:0] want);
    tests_run++;
    if (got !== want) begin
      $display("CHECK FAILED %0t %h %h", $time, got, want);
      n_errors++;
    end
  endtask
  task bus(input logic w, input logic [3:0] a, input logic [31:0] x);
    int n;
    n = 0;
    if (!hung) begin
      @(posedge ref_clk);
      avs_address <= a;
      avs_writedata <= x;
      avs_write <= w;
      avs_read <= !w;
      do begin
        @(posedge ref_clk);
        n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (avs_waitrequest !== 1'b0) begin
        n_errors++;
        hung = 1'b1;
      end
    end
  endtask
  task rd(input logic [3:0] a, input logic [31:0] x);
    exp_q.push_back(x);
    bus(1'b0, a, 32'h0000_0000);
  endtask
  always @(posedge ref_clk) begin
    if (avs_read && avs_waitrequest === 1'b0) begin
      m = exp_q.pop_front();
      compare_read(avs_readdata, m);
    end
  end
  initial begin
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd(4'h2, 32'h0000_0000);
    rd(4'h4, 32'h0000_0000);
    rd(4'h7, 32'h0000_0000);
    v = $random(seed);
    bus(1'b1, 4'h1, v);
    rd(4'h1, v & 32'h0000_00ff);
    $display("register test done");
    for (i = 0; i < 6; i++) begin
      d = $random(seed);
      e = d & 8'h0b;
      p = d[5:0] | (i[0] ? 6'h04 : 6'h00);
      bus(1'b1, 4'h3, d);
      bus(1'b1, 4'h2, {d[7:6], i[0], 5'h1f});
      rd(4'h4, {16'h0000, d[7] ? 8'h00 : e, d[6] ? 8'h00 : e});
      compare_mode(pin_input_mode, p);
    end
    $display("pin test done");
    for (i = 0; i < 6; i++) begin
      d = i < 2 ? 8'h28 | 8'(i << 4) : 8'h20 | 8'(i - 2);
      bus(1'b1, 4'h2, d);
      bus(1'b1, 4'h1, 32'h0000_0000);
      run <= 1'b1;
      repeat (256) @(posedge ref_clk);
      run <= 1'b0;
      repeat (8) @(posedge ref_clk);
      rd(4'h1, i < 2 ? 16 : 16 >> (i - 1));
    end
    $display("count test done");
    for (i = 0; i < 3; i++) begin
      d = i < 2 ? 8'h28 | 8'(i << 1) : 8'h20;
      bus(1'b1, 4'h2, d);
      repeat (4) @(posedge ref_clk);
      ticks = 8'h00;
      repeat (64) begin
        @(posedge ref_clk);
        ticks = ticks + {7'h00, watchdog_tick};
      end
      compare_ticks(ticks, i == 1 ? 8'h04 : 8'h10);
    end
    $display("watchdog test done");
    repeat (4) @(posedge ref_clk);
    print_verdict;
  end
endmodule
